// File: pohb_pkg.sv
// Constants and types for the printer output handshake buffer
package pohb_pkg;
  // ==========================================================
  // Widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int MEM_DEPTH = 4096;

  // ==========================================================
  // Buffer map
  localparam logic [11:0] USER_LO_END = 12'h0ff;
  localparam logic [11:0] FIX_LO_BEG = 12'h100;
  localparam logic [11:0] FIX_LO_END = 12'h11f;
  localparam logic [11:0] USER_HI_BEG = 12'h120;
  localparam logic [11:0] USER_HI_END = 12'h7ff;
  localparam logic [11:0] FIX_HI_BEG = 12'h800;
  localparam logic [11:0] FIX_HI_END = 12'hdff;
  localparam logic [11:0] MSG_BASE = 12'h810;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] RAW_SEND_LENGTH_OFS = 12'h000;
  localparam logic [11:0] RAW_RECEIVE_LENGTH_OFS = 12'h080;
  localparam logic [11:0] RECEIVE_TERMINATOR_CODE_OFS = 12'h100;
  localparam logic [11:0] FAULT_LAMP_OFF_STATE_OFS = 12'h101;
  localparam logic [11:0] FAULT_LAMP_OFF_REQUEST_OFS = 12'h102;
  localparam logic [11:0] WORD_BYTE_UNIT_SELECT_OFS = 12'h103;
  localparam logic [11:0] SEND_BUFFER_HEAD_OFS = 12'h104;
  localparam logic [11:0] SEND_BUFFER_SIZE_OFS = 12'h105;
  localparam logic [11:0] RECEIVE_BUFFER_HEAD_OFS = 12'h106;
  localparam logic [11:0] RECEIVE_BUFFER_SIZE_OFS = 12'h107;
  localparam logic [11:0] PRINTER_ERROR_CODE_OFS = 12'h801;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RECEIVE_TERMINATOR_CODE_RST = 16'h0d0a;
  localparam logic [15:0] WORD_BYTE_UNIT_SELECT_RST = 16'h0000;
  localparam logic [15:0] SEND_BUFFER_HEAD_RST = 16'h0000;
  localparam logic [15:0] SEND_BUFFER_SIZE_RST = 16'h0080;
  localparam logic [15:0] RECEIVE_BUFFER_HEAD_RST = 16'h0080;
  localparam logic [15:0] RECEIVE_BUFFER_SIZE_RST = 16'h0080;
  localparam logic [15:0] PRINTER_ERROR_CODE_RST = 16'h0000;

  // ==========================================================
  // Printer error codes
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_PAUSE = 16'h0007;
  localparam logic [15:0] ERR_ABORT = 16'h0008;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    HOST_BUFFER_READ_CMD,
    HOST_BUFFER_WRITE_CMD,
    MESSAGE_REGISTER_CMD,
    MESSAGE_FETCH_CMD
  } pohb_host_cmd_t;

  typedef enum logic [2:0] {S_IDLE, S_LEN, S_FETCH, S_SEND, S_DONE} pohb_state_t;

  typedef enum logic [1:0] {SRC_NONE, SRC_CPU, SRC_HOST, SRC_ENG} pohb_src_t;

  // ==========================================================
  // Decoders
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a <= FIX_HI_END);
  endfunction : is_mapped

  function automatic logic is_writable(input logic [11:0] a);
    is_writable = (a <= FIX_HI_END) && (a != FAULT_LAMP_OFF_STATE_OFS);
  endfunction : is_writable

  function automatic logic [15:0] default_val(input logic [11:0] a);
    case (a)
      RECEIVE_TERMINATOR_CODE_OFS: default_val = RECEIVE_TERMINATOR_CODE_RST;
      WORD_BYTE_UNIT_SELECT_OFS: default_val = WORD_BYTE_UNIT_SELECT_RST;
      SEND_BUFFER_HEAD_OFS: default_val = SEND_BUFFER_HEAD_RST;
      SEND_BUFFER_SIZE_OFS: default_val = SEND_BUFFER_SIZE_RST;
      RECEIVE_BUFFER_HEAD_OFS: default_val = RECEIVE_BUFFER_HEAD_RST;
      RECEIVE_BUFFER_SIZE_OFS: default_val = RECEIVE_BUFFER_SIZE_RST;
      default: default_val = 16'h0000;
    endcase
  endfunction : default_val
endpackage : pohb_pkg

// File: pohb_mem.sv
// Single-port buffer memory with registered read data
`timescale 1ns/1ps
module pohb_mem (
  // Clock
  input  wire logic        mclk,
  input  wire logic        ce,
  // Access
  input  wire logic        we,
  input  wire logic [11:0] addr,
  input  wire logic [15:0] wdata,
  output logic      [15:0] rdata_q
);
  // ==========================================================
  // Storage
  logic [15:0] mem_q [0:pohb_pkg::MEM_DEPTH-1];

  always_ff @(posedge mclk) begin
    if (ce) begin
      if (we) begin
        mem_q[addr] <= wdata;
      end
      rdata_q <= mem_q[addr];
    end
  end
endmodule : pohb_mem

// File: pohb_top.sv
// Printer output handshake and buffer memory top level
// Function
// R1 - Print request rising starts sending the message to the printer.
// R2 - Request falling mid-output aborts it as unfinished and records error 08H.
// R3 - Writing 00H to word 801H clears the printer error code.
// R4 - Pause rising during output suspends sending and records error 07H.
// R5 - Pause falling resumes sending and sets error code back to 00H.
// R6 - Finished output raises the print completion flag.
// R7 - Controller lowers the print request after seeing completion.
// R8 - Request falling after completion lowers the completion flag.
// R9 - Every buffer word is 16 bits and volatile.
// R10 - Words 0H-FFH and 120H-7FFH are a free user area.
// R11 - Words 100H-11FH and 800H-DFFH are fixed-purpose areas.
// R12 - Range 800H-DFFH serves the printer functions only.
// R13 - Reset loads defaults into every fixed-purpose word.
// R14 - Nobody writes the system-reserved fixed-purpose words.
// R15 - Controller reaches the buffer with block read and write.
// R16 - Host reaches the buffer with read, write, register, fetch commands.
// R17 - Receive terminator code resets to 0D0AH.
// R18 - Unit select resets to 0, send size to 80H, send head to 0.
// R19 - Receive head and receive size reset to 80H.
`timescale 1ns/1ps
module pohb_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Print handshake
  input  wire logic        print_req,
  input  wire logic        print_pause,
  output logic             print_done_flag,
  // Controller block read and write
  input  wire logic        cpu_req,
  input  wire logic        cpu_we,
  input  wire logic [11:0] cpu_addr,
  input  wire logic [15:0] cpu_wdata,
  output logic      [15:0] cpu_rdata,
  output logic             cpu_ack,
  // Host commands
  input  wire logic        host_req,
  input  wire logic [1:0]  host_cmd,
  input  wire logic [11:0] host_addr,
  input  wire logic [15:0] host_wdata,
  output logic      [15:0] host_rdata,
  output logic             host_ack,
  // Printer word stream
  output logic      [15:0] prn_data,
  output logic             prn_valid,
  input  wire logic        prn_ready,
  // Status
  output logic             link_ready,
  output logic      [15:0] printer_error_code
);
  // ==========================================================
  // Declarations
  pohb_pkg::pohb_state_t st_q;
  pohb_pkg::pohb_src_t   stg_q;
  logic [2:0]  sy_q [2];
  logic [1:0]  lvl_q, prv_q, pins;
  logic        req_rise, req_fall, pause_rise, pause_fall, busy;
  logic        init_q, ready_q, stg_map_q, stg_err_q;
  logic        gnt_cpu, gnt_host, gnt_eng, eng_rd, eng_wait_q, paused_q, done_q;
  logic        prn_valid_q, cpu_ack_q, host_ack_q, h_wr, mem_we;
  logic [11:0] ini_addr_q, len_q, idx_q, head_q, h_addr, mem_addr;
  logic [15:0] err_q, prn_data_q, cpu_rdata_q, host_rdata_q, mem_wdata, mem_rdata;

  // ==========================================================
  // Input synchronisers
  assign pins = {print_pause, print_req};

  genvar g;
  for (g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        sy_q[g]  <= 3'h0;
        lvl_q[g] <= 1'b0;
        prv_q[g] <= 1'b0;
      end else if (ce) begin
        sy_q[g] <= {sy_q[g][1:0], pins[g]};
        if (sy_q[g][1] == sy_q[g][2]) begin
          lvl_q[g] <= sy_q[g][2];
        end
        prv_q[g] <= lvl_q[g];
      end
    end
  end

  assign req_rise   = lvl_q[0] & ~prv_q[0];
  assign req_fall   = ~lvl_q[0] & prv_q[0];
  assign pause_rise = lvl_q[1] & ~prv_q[1];
  assign pause_fall = ~lvl_q[1] & prv_q[1];
  assign busy = (st_q == pohb_pkg::S_LEN) || (st_q == pohb_pkg::S_FETCH)
             || (st_q == pohb_pkg::S_SEND);

  // ==========================================================
  // Default loader over fixed-purpose words
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      init_q     <= 1'b1;
      ini_addr_q <= pohb_pkg::FIX_LO_BEG;
      ready_q    <= 1'b0;
    end else if (ce) begin
      if (init_q) begin
        if (ini_addr_q == pohb_pkg::FIX_LO_END) begin
          ini_addr_q <= pohb_pkg::FIX_HI_BEG; // R11
        end else if (ini_addr_q == pohb_pkg::FIX_HI_END) begin
          init_q <= 1'b0; // R13
        end else begin
          ini_addr_q <= ini_addr_q + 12'h001;
        end
      end
      ready_q <= ~init_q;
    end
  end

  // ==========================================================
  // Access arbitration
  assign h_addr = (host_cmd == pohb_pkg::MESSAGE_REGISTER_CMD
                || host_cmd == pohb_pkg::MESSAGE_FETCH_CMD)
                ? 12'(pohb_pkg::MSG_BASE + host_addr) : host_addr; // R12
  assign h_wr = (host_cmd == pohb_pkg::HOST_BUFFER_WRITE_CMD)
             || (host_cmd == pohb_pkg::MESSAGE_REGISTER_CMD);
  assign gnt_cpu = ~init_q & cpu_req & (stg_q != pohb_pkg::SRC_CPU) & ~cpu_ack_q; // R15
  assign gnt_host = ~init_q & ~gnt_cpu & host_req
                  & (stg_q != pohb_pkg::SRC_HOST) & ~host_ack_q; // R16
  assign gnt_eng = ~init_q & ~gnt_cpu & ~gnt_host & eng_rd;

  always_comb begin
    mem_we    = 1'b0;
    mem_addr  = 12'h000;
    mem_wdata = 16'h0000;
    if (init_q) begin
      mem_we    = 1'b1;
      mem_addr  = ini_addr_q;
      mem_wdata = pohb_pkg::default_val(ini_addr_q); // R13 R17 R18 R19
    end else if (gnt_cpu) begin
      mem_we    = cpu_we & pohb_pkg::is_writable(cpu_addr); // R10
      mem_addr  = cpu_addr;
      mem_wdata = cpu_wdata;
    end else if (gnt_host) begin
      mem_we    = h_wr & pohb_pkg::is_writable(h_addr);
      mem_addr  = h_addr;
      mem_wdata = host_wdata;
    end else if (gnt_eng) begin
      mem_addr = 12'(head_q + ((st_q == pohb_pkg::S_LEN) ? 12'h000 : idx_q + 12'h001));
    end
  end

  pohb_mem pohb_mem_i (
    .mclk    (mclk),
    .ce      (ce),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (mem_wdata),
    .rdata_q (mem_rdata)
  ); // R9

  // ==========================================================
  // Answers to controller and host
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stg_q        <= pohb_pkg::SRC_NONE;
      stg_map_q    <= 1'b0;
      stg_err_q    <= 1'b0;
      cpu_ack_q    <= 1'b0;
      cpu_rdata_q  <= 16'h0000;
      host_ack_q   <= 1'b0;
      host_rdata_q <= 16'h0000;
    end else if (ce) begin
      stg_q <= gnt_cpu ? pohb_pkg::SRC_CPU : gnt_host ? pohb_pkg::SRC_HOST
             : gnt_eng ? pohb_pkg::SRC_ENG : pohb_pkg::SRC_NONE;
      stg_map_q <= pohb_pkg::is_mapped(mem_addr);
      stg_err_q <= (mem_addr == pohb_pkg::PRINTER_ERROR_CODE_OFS);
      cpu_ack_q  <= (stg_q == pohb_pkg::SRC_CPU);
      host_ack_q <= (stg_q == pohb_pkg::SRC_HOST);
      if (stg_q == pohb_pkg::SRC_CPU) begin
        cpu_rdata_q <= ~stg_map_q ? 16'h0000 : stg_err_q ? err_q : mem_rdata;
      end
      if (stg_q == pohb_pkg::SRC_HOST) begin
        host_rdata_q <= ~stg_map_q ? 16'h0000 : stg_err_q ? err_q : mem_rdata;
      end
    end
  end

  // Shadow of the send buffer head word
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      head_q <= pohb_pkg::SEND_BUFFER_HEAD_RST[11:0]; // R18
    end else if (ce && mem_we && mem_addr == pohb_pkg::SEND_BUFFER_HEAD_OFS) begin
      head_q <= mem_wdata[11:0];
    end
  end

  // ==========================================================
  // Print engine
  assign eng_rd = ((st_q == pohb_pkg::S_LEN) || (st_q == pohb_pkg::S_FETCH))
               & ~eng_wait_q & ~paused_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q        <= pohb_pkg::S_IDLE;
      eng_wait_q  <= 1'b0;
      len_q       <= 12'h000;
      idx_q       <= 12'h000;
      prn_data_q  <= 16'h0000;
      prn_valid_q <= 1'b0;
    end else if (ce) begin
      if (busy && req_fall) begin
        st_q        <= pohb_pkg::S_IDLE; // R2
        eng_wait_q  <= 1'b0;
        prn_valid_q <= 1'b0;
      end else begin
        case (st_q)
          pohb_pkg::S_IDLE: begin
            if (req_rise && !init_q) begin
              st_q  <= pohb_pkg::S_LEN; // R1
              idx_q <= 12'h000;
            end
          end
          pohb_pkg::S_LEN, pohb_pkg::S_FETCH: begin
            if (gnt_eng) begin
              eng_wait_q <= 1'b1;
            end
            if (stg_q == pohb_pkg::SRC_ENG) begin
              eng_wait_q <= 1'b0;
              if (st_q == pohb_pkg::S_LEN) begin
                len_q <= mem_rdata[11:0];
                st_q  <= (mem_rdata[11:0] == 12'h000) ? pohb_pkg::S_DONE
                       : pohb_pkg::S_FETCH;
              end else begin
                prn_data_q  <= mem_rdata;
                prn_valid_q <= 1'b1;
                st_q        <= pohb_pkg::S_SEND;
              end
            end
          end
          pohb_pkg::S_SEND: begin
            if (prn_ready) begin
              prn_valid_q <= 1'b0;
              idx_q       <= idx_q + 12'h001;
              st_q <= (idx_q + 12'h001 == len_q) ? pohb_pkg::S_DONE
                    : pohb_pkg::S_FETCH;
            end
          end
          pohb_pkg::S_DONE: begin
            if (!lvl_q[0]) begin
              st_q <= pohb_pkg::S_IDLE;
            end
          end
          default: st_q <= pohb_pkg::S_IDLE;
        endcase
      end
    end
  end

  // Completion flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else if (ce) begin
      if (!lvl_q[0]) begin
        done_q <= 1'b0; // R8
      end else if (st_q == pohb_pkg::S_DONE) begin
        done_q <= 1'b1; // R6
      end
    end
  end

  // Pause and error code; hardware events win over software writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      paused_q <= 1'b0;
      err_q    <= pohb_pkg::PRINTER_ERROR_CODE_RST;
    end else if (ce) begin
      if (mem_we && !init_q && mem_addr == pohb_pkg::PRINTER_ERROR_CODE_OFS) begin
        err_q <= mem_wdata; // R3
      end
      if (busy && req_fall) begin
        err_q    <= pohb_pkg::ERR_ABORT; // R2
        paused_q <= 1'b0;
      end else if (busy && pause_rise) begin
        err_q    <= pohb_pkg::ERR_PAUSE; // R4
        paused_q <= 1'b1;
      end else if (paused_q && pause_fall) begin
        err_q    <= pohb_pkg::ERR_NONE; // R5
        paused_q <= 1'b0;
      end else if (!busy) begin
        paused_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign print_done_flag    = done_q;
  assign cpu_rdata          = cpu_rdata_q;
  assign cpu_ack            = cpu_ack_q;
  assign host_rdata         = host_rdata_q;
  assign host_ack           = host_ack_q;
  assign prn_data           = prn_data_q;
  assign prn_valid          = prn_valid_q;
  assign link_ready         = ready_q;
  assign printer_error_code = err_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_start_on_req: assert property (ce && st_q == pohb_pkg::S_IDLE && req_rise && !init_q
    |=> st_q == pohb_pkg::S_LEN) else $error("request rise did not start output"); // R1
  a_abort_err: assert property (ce && busy && req_fall
    |=> st_q == pohb_pkg::S_IDLE && err_q == pohb_pkg::ERR_ABORT && !prn_valid_q)
    else $error("abort not handled"); // R2
  a_err_clear: assert property (ce && mem_we && !init_q && mem_wdata == 16'h0000
    && mem_addr == pohb_pkg::PRINTER_ERROR_CODE_OFS && !busy |=> err_q == 16'h0000)
    else $error("error code not cleared"); // R3
  a_pause_err: assert property (ce && busy && pause_rise && !req_fall
    |=> paused_q && err_q == pohb_pkg::ERR_PAUSE && !eng_rd) else $error("pause not taken"); // R4
  a_resume_ok: assert property (ce && paused_q && pause_fall && !(busy && req_fall)
    |=> !paused_q && err_q == pohb_pkg::ERR_NONE) else $error("resume not taken"); // R5
  a_done_rise: assert property (ce && st_q == pohb_pkg::S_DONE && lvl_q[0]
    |=> done_q) else $error("completion flag not raised"); // R6
  a_done_drop: assert property (ce && !lvl_q[0] |=> !done_q)
    else $error("completion flag not lowered"); // R8
  a_map_write: assert property (mem_we |-> mem_addr <= pohb_pkg::FIX_HI_END)
    else $error("write outside buffer map"); // R11
  a_init_term: assert property (init_q && mem_addr == pohb_pkg::RECEIVE_TERMINATOR_CODE_OFS
    |-> mem_wdata == 16'h0d0a) else $error("bad terminator default"); // R17
  a_cpu_answer: assert property (ce && gnt_cpu ##1 ce |=> cpu_ack_q)
    else $error("controller answer late"); // R15
  a_host_answer: assert property (ce && gnt_host ##1 ce |=> host_ack_q)
    else $error("host answer late"); // R16

  c_full_print: cover property (ce && st_q == pohb_pkg::S_DONE ##1 done_q);
  c_abort: cover property (ce && busy && req_fall);
  c_pause_resume: cover property (paused_q ##[1:200] !paused_q && busy);
  c_host_write: cover property (gnt_host && mem_we);
endmodule : pohb_top

// File: pohb_prn_sink.sv
// Printer sink model that accepts the word stream with a set stall
`timescale 1ns/1ps
module pohb_prn_sink (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Word stream
  input  wire logic [15:0] prn_data,
  input  wire logic        prn_valid,
  output logic             prn_ready,
  // Stall control
  input  wire logic [3:0]  delay
);
  // ==========================================================
  // Acceptance
  logic [15:0] words [64];
  int          cnt;
  logic [3:0]  wait_q;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prn_ready <= 1'b0;
      cnt       <= 0;
      wait_q    <= 4'h0;
    end else if (prn_valid && prn_ready) begin
      words[cnt] <= prn_data;
      cnt        <= cnt + 1;
      prn_ready  <= 1'b0;
      wait_q     <= 4'h0;
    end else if (prn_valid) begin
      prn_ready <= (wait_q >= delay);
      if (wait_q != 4'hf) wait_q <= wait_q + 4'h1;
    end else begin
      prn_ready <= 1'b0;
      wait_q    <= 4'h0;
    end
  end
endmodule : pohb_prn_sink

// File: printer_output_handshake_buffer_tb.sv
// Testbench for the printer output handshake buffer
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module printer_output_handshake_buffer_tb;
  // ==========================================================
  // Signals
  logic        mclk = 1'b0, rst = 1'b1, print_req = 1'b0, print_pause = 1'b0;
  logic        ce = 1'b1;
  logic        cpu_req = 1'b0, cpu_we = 1'b0, host_req = 1'b0;
  logic [1:0]  host_cmd = 2'h0;
  logic [11:0] cpu_addr = 12'h000, host_addr = 12'h000;
  logic [15:0] cpu_wdata = 16'h0000, host_wdata = 16'h0000, q, c;
  logic [15:0] cpu_rdata, host_rdata, prn_data, printer_error_code;
  logic        print_done_flag, cpu_ack, host_ack, prn_valid, prn_ready, link_ready;
  logic [3:0]  dly = 4'h0;
  logic [15:0] dflt [8] = '{16'h0d0a, 16'h0000, 16'h0000, 16'h0000,
                            16'h0000, 16'h0080, 16'h0080, 16'h0080};
  int          failures = 0, cmp_count = 0, base;

  always #12.5 mclk = ~mclk;

  pohb_top pohb_top_i (
    .mclk(mclk), .rst(rst), .ce(ce), .print_req(print_req), .print_pause(print_pause),
    .print_done_flag(print_done_flag), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack),
    .host_req(host_req), .host_cmd(host_cmd), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_ack(host_ack),
    .prn_data(prn_data), .prn_valid(prn_valid), .prn_ready(prn_ready),
    .link_ready(link_ready), .printer_error_code(printer_error_code)
  );

  pohb_prn_sink pohb_prn_sink_i (
    .mclk(mclk), .rst(rst), .prn_data(prn_data), .prn_valid(prn_valid),
    .prn_ready(prn_ready), .delay(dly)
  );

  // ==========================================================
  // Access tasks
  task automatic bus(input logic h, input logic [1:0] cm, input logic w,
                     input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    if (h) begin
      host_req   = 1'b1;
      host_cmd   = cm;
      host_addr  = a;
      host_wdata = d;
    end else begin
      cpu_req   = 1'b1;
      cpu_we    = w;
      cpu_addr  = a;
      cpu_wdata = d;
    end
    do begin
      @(negedge mclk);
      n++;
    end while ((h ? host_ack : cpu_ack) !== 1'b1 && n < 50);
    q = h ? host_rdata : cpu_rdata;
    @(negedge mclk);
    cpu_req  = 1'b0;
    host_req = 1'b0;
    if (n >= 50) `CHK("access ack", 1'b1, 1'b0)
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    bus(1'b0, 2'h0, 1'b1, a, d);
  endtask : wr

  task automatic rd(input logic h, input logic [1:0] cm, input logic [11:0] a,
                    input logic [15:0] e);
    bus(h, cm, 1'b0, a, 16'h0000);
    `CHK("read data", e, q)
  endtask : rd

  task automatic wait_for(input int sel, input int v);
    int n;
    n = 0;
    while (n < 2000 && !((sel == 0) ? (print_done_flag === v[0]) :
           (sel == 1) ? (pohb_prn_sink_i.cnt >= v) : (link_ready === 1'b1))) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 2000) `CHK("wait", 1'b1, 1'b0)
  endtask : wait_for

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Watchdog
  initial begin
    #(25 * 12000);
    `CHK("watchdog", 1'b1, 1'b0)
    give_verdict();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    wait_for(2, 0);
    for (int k = 0; k < 8; k++) rd(1'b0, 2'h0, 12'(12'h100 + k), dflt[k]);
    `CHK("error code", 16'h0000, printer_error_code)
    wr(12'h101, 16'hffff);
    rd(1'b0, 2'h0, 12'h101, 16'h0000);
    wr(12'he00, 16'h1234);
    rd(1'b0, 2'h0, 12'he00, 16'h0000);
    wr(12'h0ff, 16'ha55a);
    rd(1'b1, 2'h0, 12'h0ff, 16'ha55a);
    bus(1'b1, 2'h1, 1'b0, 12'h7ff, 16'hffff);
    rd(1'b0, 2'h0, 12'h7ff, 16'hffff);
    bus(1'b1, 2'h2, 1'b0, 12'h005, 16'hbeef);
    rd(1'b1, 2'h3, 12'h005, 16'hbeef);
    rd(1'b0, 2'h0, 12'h815, 16'hbeef);
    wr(12'h105, 16'h0010);
    wr(12'h104, 16'h0200);
    wr(12'h200, 16'h0004);
    for (int k = 1; k < 5; k++) wr(12'(12'h200 + k), 16'(16'ha000 + k));
    // Plain output
    base = pohb_prn_sink_i.cnt;
    @(negedge mclk) print_req = 1'b1;
    wait_for(0, 1);
    `CHK("words sent", base + 4, pohb_prn_sink_i.cnt)
    for (int k = 0; k < 4; k++)
      `CHK("word", 16'(16'ha001 + k), pohb_prn_sink_i.words[base + k])
    @(negedge mclk) print_req = 1'b0;
    wait_for(0, 0);
    `CHK("done low", 1'b0, print_done_flag)
    // Pause and resume
    dly = 4'h6;
    @(negedge mclk) print_req = 1'b1;
    wait_for(1, base + 5);
    @(negedge mclk) print_pause = 1'b1;
    repeat (25) @(negedge mclk);
    c = 16'(pohb_prn_sink_i.cnt);
    `CHK("pause error", 16'h0007, printer_error_code)
    rd(1'b0, 2'h0, 12'h801, 16'h0007);
    repeat (20) @(negedge mclk);
    `CHK("paused count", c, 16'(pohb_prn_sink_i.cnt))
    `CHK("paused done", 1'b0, print_done_flag)
    @(negedge mclk) print_pause = 1'b0;
    repeat (12) @(negedge mclk);
    `CHK("resume error", 16'h0000, printer_error_code)
    wait_for(0, 1);
    `CHK("resumed count", base + 8, pohb_prn_sink_i.cnt)
    @(negedge mclk) print_req = 1'b0;
    wait_for(0, 0);
    // Abort
    @(negedge mclk) print_req = 1'b1;
    wait_for(1, base + 9);
    @(negedge mclk) print_req = 1'b0;
    repeat (40) @(negedge mclk);
    `CHK("abort error", 16'h0008, printer_error_code)
    `CHK("abort done", 1'b0, print_done_flag)
    `CHK("abort stop", 1'b1, pohb_prn_sink_i.cnt < base + 11)
    wr(12'h801, 16'h0000);
    `CHK("error cleared", 16'h0000, printer_error_code)
    rd(1'b0, 2'h0, 12'h801, 16'h0000);
    // Clock enable low stretches an access
    fork
      rd(1'b0, 2'h0, 12'h801, 16'h0000);
      begin
        @(negedge mclk) ce = 1'b0;
        repeat (4) @(negedge mclk);
        ce = 1'b1;
      end
    join
    // Reset reloads defaults
    @(negedge mclk) rst = 1'b1;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    wait_for(2, 0);
    rd(1'b0, 2'h0, 12'h105, 16'h0080);
    rd(1'b0, 2'h0, 12'h104, 16'h0000);
    give_verdict();
  end
endmodule : printer_output_handshake_buffer_tb
